// >>> pci_pin_change.v
// pin change interrupt block with classic wishbone register slave
`timescale 1ns/100ps
`include "pci_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RL1] every implemented pin of both ports detects changes
// [RL2] rising or falling edge raises change interrupt
// [RL3] each pin configured independently
// [RL4] master off: flags still set, no request
// [RL5] rising detector gated by rise enable bit
// [RL6] falling detector gated by fall enable bit
// [RL7] both enables set detect both directions
// [RL8] edge sets sticky flag; request needs master
// [RL9] summary flag is OR of all flags
// [RL10] software clears flag by writing zero
// [RL11] edge during write keeps flag set
// [RL12] software clears flags with AND mask only; the flag registers store the written value, so a written 1 sets a flag
// [RL13] enabled edge wakes sleeping device when master
// [RL14] sleep edge recorded before wake completes
// [RL15] first port has bits 5-3, 1-0 only
// [RL16] pins synchronised, compared with previous sample
module pci_pin_change #(
	parameter WIDTH = 8
) (
	input wire clock,
	input wire rst_n,
	input wire [WIDTH-1:0] first_gpio_port,
	input wire [WIDTH-1:0] second_gpio_port,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output wire wb_err_o,
	output wire change_irq_summary_flag,
	output wire pin_change_interrupt,
	output wire wake_request,
	output wire irq
);
	reg [WIDTH-1:0] port_a_rise_enable;
	reg [WIDTH-1:0] port_a_fall_enable;
	reg [WIDTH-1:0] port_b_rise_enable;
	reg [WIDTH-1:0] port_b_fall_enable;
	reg [WIDTH-1:0] port_a_change_flags;
	reg [WIDTH-1:0] port_b_change_flags;
	reg change_irq_master_enable;
	reg sleep_mode;
	reg [`PCI_EVT_W-1:0] irq_status;
	reg [`PCI_EVT_W-1:0] irq_mask;
	wire [WIDTH-1:0] hit_a;
	wire [WIDTH-1:0] hit_b;
	wire [WIDTH-1:0] impl_a;
	wire [WIDTH-1:0] impl_b;
	wire req;
	wire wr_lane0;
	wire rd_req;
	wire [3:0] word_idx;
	wire addr_ok;
	reg [WIDTH-1:0] next_flags_a;
	reg [WIDTH-1:0] next_flags_b;
	reg [`PCI_EVT_W-1:0] events;
	reg [31:0] next_rdata;
	// one write strobe per writable register, one read strobe for status
	wire wr_a_rise;
	wire wr_a_fall;
	wire wr_a_flags;
	wire wr_b_rise;
	wire wr_b_fall;
	wire wr_b_flags;
	wire wr_ctrl;
	wire wr_mask;
	wire rd_stat;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	function [3:0] word_of;
		input [5:0] adr;
		begin
			word_of = adr[5:2];
		end
	endfunction

	function [WIDTH-1:0] widen;
		input [7:0] val;
		begin
			widen = val[WIDTH-1:0];
		end
	endfunction

	// one compare per register so the strobes cannot drift apart
	function is_word;
		input [3:0] idx;
		input [3:0] target;
		begin
			is_word = (idx == target);
		end
	endfunction

	function [WIDTH-1:0] keep_impl;
		input [31:0] d;
		input [WIDTH-1:0] impl;
		begin
			keep_impl = d[WIDTH-1:0] & impl;
		end
	endfunction

	assign impl_a = widen(`PCI_PORT_A_IMPL); // RL15
	assign impl_b = widen(`PCI_PORT_B_IMPL);
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign word_idx = word_of(wb_adr_i);
	assign addr_ok = (word_idx <= `PCI_ADDR_IRQ_MASK);
	assign wr_lane0 = req & wb_we_i & wb_sel_i[0] & addr_ok;
	assign rd_req = req & ~wb_we_i & addr_ok;
	assign wr_a_rise = wr_lane0 & is_word(word_idx, `PCI_ADDR_A_RISE);
	assign wr_a_fall = wr_lane0 & is_word(word_idx, `PCI_ADDR_A_FALL);
	assign wr_a_flags = wr_lane0 & is_word(word_idx, `PCI_ADDR_A_FLAGS);
	assign wr_b_rise = wr_lane0 & is_word(word_idx, `PCI_ADDR_B_RISE);
	assign wr_b_fall = wr_lane0 & is_word(word_idx, `PCI_ADDR_B_FALL);
	assign wr_b_flags = wr_lane0 & is_word(word_idx, `PCI_ADDR_B_FLAGS);
	assign wr_ctrl = wr_lane0 & is_word(word_idx, `PCI_ADDR_CTRL);
	assign wr_mask = wr_lane0 & is_word(word_idx, `PCI_ADDR_IRQ_MASK);
	assign rd_stat = rd_req & is_word(word_idx, `PCI_ADDR_IRQ_STAT);
	// unmapped words ack and read zero rather than raise err
	assign wb_err_o = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// edge detectors, one per port

	pci_edge_detect #(
		.WIDTH(WIDTH),
		.IMPL(`PCI_PORT_A_IMPL)
	) u_det_a (
		.clock(clock),
		.rst_n(rst_n),
		.pins(first_gpio_port), // RL1
		.rise_en(port_a_rise_enable),
		.fall_en(port_a_fall_enable),
		.edge_hit(hit_a)
	);

	pci_edge_detect #(
		.WIDTH(WIDTH),
		.IMPL(`PCI_PORT_B_IMPL)
	) u_det_b (
		.clock(clock),
		.rst_n(rst_n),
		.pins(second_gpio_port), // RL1
		.rise_en(port_b_rise_enable),
		.fall_en(port_b_fall_enable),
		.edge_hit(hit_b)
	);

	////////////////////////////////////////////////////////////////////////
	// flags: write stores data, a fresh edge always wins

	always @* begin
		next_flags_a = port_a_change_flags;
		next_flags_b = port_b_change_flags;
		if (wr_a_flags) begin
			next_flags_a = keep_impl(wb_dat_i, impl_a); // RL10
		end
		if (wr_b_flags) begin
			next_flags_b = keep_impl(wb_dat_i, impl_b); // RL10
		end
		// the set term comes last so a detected edge beats the write
		next_flags_a = next_flags_a | hit_a; // RL8 RL11
		next_flags_b = next_flags_b | hit_b; // RL8 RL11
	end

	// flags update in sleep too, ahead of wake
	always @(posedge clock) begin
		if (!rst_n) begin
			port_a_change_flags <= {WIDTH{1'b0}};
		end else begin
			port_a_change_flags <= next_flags_a; // RL14
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			port_b_change_flags <= {WIDTH{1'b0}};
		end else begin
			port_b_change_flags <= next_flags_b; // RL14
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	always @(posedge clock) begin
		if (!rst_n) begin
			port_a_rise_enable <= {WIDTH{1'b0}};
		end else if (wr_a_rise) begin
			port_a_rise_enable <= keep_impl(wb_dat_i, impl_a); // RL3
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			port_a_fall_enable <= {WIDTH{1'b0}};
		end else if (wr_a_fall) begin
			port_a_fall_enable <= keep_impl(wb_dat_i, impl_a); // RL3
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			port_b_rise_enable <= {WIDTH{1'b0}};
		end else if (wr_b_rise) begin
			port_b_rise_enable <= keep_impl(wb_dat_i, impl_b); // RL3
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			port_b_fall_enable <= {WIDTH{1'b0}};
		end else if (wr_b_fall) begin
			port_b_fall_enable <= keep_impl(wb_dat_i, impl_b); // RL3
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			irq_mask <= {`PCI_EVT_W{1'b0}};
		end else if (wr_mask) begin
			irq_mask <= wb_dat_i[`PCI_EVT_W-1:0];
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			change_irq_master_enable <= 1'b0;
		end else if (wr_ctrl) begin
			change_irq_master_enable <=
				wb_dat_i[`PCI_CTRL_MASTER_BIT];
		end
	end

	// leaving sleep is automatic once wake is raised; a write wins
	always @(posedge clock) begin
		if (!rst_n) begin
			sleep_mode <= 1'b0;
		end else if (wr_ctrl) begin
			sleep_mode <= wb_dat_i[`PCI_CTRL_SLEEP_BIT];
		end else if (wake_request) begin
			sleep_mode <= 1'b0; // RL13
		end
	end

	////////////////////////////////////////////////////////////////////////
	// summary, request and wake

	assign change_irq_summary_flag = |{port_a_change_flags,
		port_b_change_flags}; // RL9
	assign pin_change_interrupt = change_irq_summary_flag &
		change_irq_master_enable; // RL4 RL8 RL2
	assign wake_request = sleep_mode & pin_change_interrupt; // RL13

	////////////////////////////////////////////////////////////////////////
	// sticky event status, cleared by reading it

	// the wake event only counts while asleep with the master on
	always @* begin
		events = {`PCI_EVT_W{1'b0}};
		events[`PCI_EVT_A_BIT] = |hit_a;
		events[`PCI_EVT_B_BIT] = |hit_b;
		events[`PCI_EVT_WAKE_BIT] = sleep_mode & |{hit_a, hit_b} &
			change_irq_master_enable;
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			irq_status <= {`PCI_EVT_W{1'b0}};
		end else if (rd_stat) begin
			// a same-cycle event survives the read clear
			irq_status <= events;
		end else begin
			irq_status <= irq_status | events;
		end
	end

	assign irq = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////
	// read mux and single-cycle ack

	// unmapped words fall to the default and read zero
	always @* begin
		next_rdata = 32'h00000000;
		case (word_idx)
		`PCI_ADDR_A_RISE: begin
			next_rdata[WIDTH-1:0] = port_a_rise_enable;
		end
		`PCI_ADDR_A_FALL: begin
			next_rdata[WIDTH-1:0] = port_a_fall_enable;
		end
		`PCI_ADDR_A_FLAGS: begin
			next_rdata[WIDTH-1:0] = port_a_change_flags;
		end
		`PCI_ADDR_B_RISE: begin
			next_rdata[WIDTH-1:0] = port_b_rise_enable;
		end
		`PCI_ADDR_B_FALL: begin
			next_rdata[WIDTH-1:0] = port_b_fall_enable;
		end
		`PCI_ADDR_B_FLAGS: begin
			next_rdata[WIDTH-1:0] = port_b_change_flags;
		end
		`PCI_ADDR_CTRL: begin
			next_rdata[`PCI_CTRL_MASTER_BIT] = change_irq_master_enable;
			next_rdata[`PCI_CTRL_SLEEP_BIT] = sleep_mode;
			next_rdata[2] = change_irq_summary_flag;
		end
		`PCI_ADDR_IRQ_STAT: begin
			next_rdata[`PCI_EVT_W-1:0] = irq_status;
		end
		`PCI_ADDR_IRQ_MASK: begin
			next_rdata[`PCI_EVT_W-1:0] = irq_mask;
		end
		default: begin
			next_rdata = 32'h00000000;
		end
		endcase
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// read data holds until the next read
	always @(posedge clock) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h00000000;
		end else if (req && !wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end
endmodule // pci_pin_change

// >>> pci_regs.vh
// register offsets, field positions and reset values of the pin change block
`ifndef PCI_REGS_VH
`define PCI_REGS_VH
`define PCI_ADDR_A_RISE 4'h0
`define PCI_ADDR_A_FALL 4'h1
`define PCI_ADDR_A_FLAGS 4'h2
`define PCI_ADDR_B_RISE 4'h3
`define PCI_ADDR_B_FALL 4'h4
`define PCI_ADDR_B_FLAGS 4'h5
`define PCI_ADDR_CTRL 4'h6
`define PCI_ADDR_IRQ_STAT 4'h7
`define PCI_ADDR_IRQ_MASK 4'h8
`define PCI_PORT_A_IMPL 8'h3B
`define PCI_PORT_B_IMPL 8'hFF
`define PCI_CTRL_MASTER_BIT 0
`define PCI_CTRL_SLEEP_BIT 1
`define PCI_EVT_A_BIT 0
`define PCI_EVT_B_BIT 1
`define PCI_EVT_WAKE_BIT 2
`define PCI_EVT_W 3
`define PCI_RESET_BYTE 8'h00
`endif

// >>> pci_edge_detect.v
// per-pin synchroniser and enabled edge detector for one port
`timescale 1ns/100ps
module pci_edge_detect #(
	parameter WIDTH = 8,
	parameter [7:0] IMPL = 8'hFF
) (
	input wire clock,
	input wire rst_n,
	input wire [WIDTH-1:0] pins,
	input wire [WIDTH-1:0] rise_en,
	input wire [WIDTH-1:0] fall_en,
	output wire [WIDTH-1:0] edge_hit
);
	reg [WIDTH-1:0] sync_a;
	reg [WIDTH-1:0] sync_b;
	reg [WIDTH-1:0] prev;
	reg [2:0] primed;

	always @(posedge clock) begin
		if (!rst_n) begin
			sync_a <= {WIDTH{1'b0}};
			sync_b <= {WIDTH{1'b0}};
			prev <= {WIDTH{1'b0}};
			primed <= 3'b000;
		end else begin
			sync_a <= pins; // RL16
			sync_b <= sync_a; // RL16
			prev <= sync_b;
			primed <= {primed[1:0], 1'b1};
		end
	end

	// no edges before the history register holds a real sample,
	// so a pin that idles high through reset gives no false edge
	assign edge_hit = primed[2] ? ((sync_b & ~prev & rise_en) | // RL5 RL7
		(~sync_b & prev & fall_en)) & IMPL[WIDTH-1:0] : // RL6 RL7
		{WIDTH{1'b0}};
endmodule // pci_edge_detect

// >>> pci_pin_change_chk.sv
// port assertions for the pin change block
`timescale 1ns/100ps
module pci_chk #(
	parameter WIDTH = 8
) (
	input wire clock,
	input wire rst_n,
	input wire [WIDTH-1:0] first_gpio_port,
	input wire [WIDTH-1:0] second_gpio_port,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire wb_err_o,
	input wire change_irq_summary_flag,
	input wire pin_change_interrupt,
	input wire wake_request,
	input wire irq
);
	reg [2*WIDTH-1:0] prev;
	reg [3:0] chg;
	wire [2*WIDTH-1:0] now = {first_gpio_port, second_gpio_port};
	// pin edges reach the flags a few cycles late
	always @(posedge clock) begin
		prev <= now;
		chg <= rst_n ? {chg[2:0], now != prev} : 4'h0;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_ERR: assert property (!wb_err_o)
		else $error("err raised");
	AST_DAT: assert property (!wb_ack_o |-> $stable(wb_dat_o))
		else $error("read data moved");
	AST_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper bits set");
	AST_REQ: assert property (pin_change_interrupt |-> change_irq_summary_flag)
		else $error("request without flag");
	AST_WAKE: assert property (wake_request |-> pin_change_interrupt)
		else $error("wake without request");
	AST_SET: assert property ($rose(change_irq_summary_flag) |-> wb_ack_o || |chg)
		else $error("flag without cause");
	AST_CLR: assert property ($fell(change_irq_summary_flag) |-> wb_ack_o)
		else $error("flag cleared by itself");
	AST_IRQ: assert property ($fell(irq) |-> wb_ack_o)
		else $error("irq dropped by itself");
endmodule // pci_chk

// >>> tb_top.sv
// self-checking bench for the pin change block
`timescale 1ns/100ps
`include "pci_regs.vh"
module tb_top;
	reg clock = 1'b0;
	reg rst_n = 1'b0;
	reg cyc = 1'b0;
	reg we = 1'b0;
	reg [3:0] sel = 4'hF;
	reg [5:0] adr = 6'h00;
	reg [31:0] dat = 32'h00000000;
	reg [7:0] pa = 8'h00;
	reg [7:0] pb = 8'h00;
	reg [31:0] got;
	wire [31:0] rdat;
	wire ack, err, sum, pci, wake, irq;
	integer errors = 0;
	integer cmp_count = 0;
	integer cyc_n = 0;
	integer i;
	pci_pin_change dut (.clock(clock), .rst_n(rst_n),
		.first_gpio_port(pa), .second_gpio_port(pb), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.change_irq_summary_flag(sum), .pin_change_interrupt(pci),
		.wake_request(wake), .irq(irq));
	initial forever #50 clock = ~clock;
	initial forever @(posedge clock) begin
		cyc_n = cyc_n + 1;
		if (cyc_n == 4000) begin
			errors = errors + 1;
			give_verdict;
		end
	end
	task give_verdict;
		if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		@(posedge clock);
		cyc <= 1'b1;
		we <= w;
		adr <= {a, 2'b00};
		dat <= d;
		@(posedge clock);
		while (ack !== 1'b1) @(posedge clock);
		got = rdat;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task rd(input [3:0] a, input [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("reg", e, got);
	endtask
	task pins(input [7:0] a, input [7:0] b);
		@(posedge clock);
		pa <= a;
		pb <= b;
		repeat (4) @(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs;
		for (i = 0; i < 10; i = i + 1) rd(i, `PCI_RESET_BYTE);
		bus(1'b1, `PCI_ADDR_A_RISE, 32'hFF);
		rd(`PCI_ADDR_A_RISE, `PCI_PORT_A_IMPL);
		bus(1'b1, `PCI_ADDR_A_FALL, 32'hFF);
		bus(1'b1, 4'h9, 32'hFF);
		rd(4'h9, 32'h0);
		sel <= 4'hE;
		bus(1'b1, `PCI_ADDR_B_RISE, 32'hFF);
		sel <= 4'hF;
		rd(`PCI_ADDR_B_RISE, 32'h0);
	endtask
	task t_edges;
		bus(1'b1, `PCI_ADDR_B_RISE, 32'h0F);
		bus(1'b1, `PCI_ADDR_B_FALL, 32'h3C);
		pins(8'hFF, 8'hFF);
		rd(`PCI_ADDR_B_FLAGS, 32'h0F);
		rd(`PCI_ADDR_A_FLAGS, `PCI_PORT_A_IMPL);
		chk("sum", 1, sum);
		chk("pci", 0, pci);
		bus(1'b1, `PCI_ADDR_CTRL, 32'h1);
		chk("pci", 1, pci);
		bus(1'b1, `PCI_ADDR_A_FLAGS, 32'h0);
		bus(1'b1, `PCI_ADDR_B_FLAGS, 32'h0);
		chk("sum", 0, sum);
		pins(8'h00, 8'h00);
		rd(`PCI_ADDR_B_FLAGS, 32'h3C);
		bus(1'b1, `PCI_ADDR_A_FLAGS, 32'h0);
		bus(1'b1, `PCI_ADDR_B_FLAGS, 32'h0);
	endtask
	task t_race;
		// edge lands on the very edge that takes the clearing write
		@(posedge clock);
		pb <= 8'h01;
		@(posedge clock);
		bus(1'b1, `PCI_ADDR_B_FLAGS, 32'h0);
		rd(`PCI_ADDR_B_FLAGS, 32'h01);
		rd(`PCI_ADDR_IRQ_STAT, 32'h3);
		rd(`PCI_ADDR_IRQ_STAT, 32'h0);
	endtask
	task t_irq;
		bus(1'b1, `PCI_ADDR_IRQ_MASK, 32'h2);
		pins(8'h00, 8'h04);
		chk("irq", 1, irq);
		rd(`PCI_ADDR_IRQ_STAT, 32'h2);
		chk("irq", 0, irq);
		bus(1'b1, `PCI_ADDR_IRQ_MASK, 32'h1);
		pins(8'h00, 8'h00);
		chk("irq", 0, irq);
		rd(`PCI_ADDR_IRQ_STAT, 32'h2);
	endtask
	task t_sleep;
		bus(1'b1, `PCI_ADDR_B_FLAGS, 32'h0);
		bus(1'b1, `PCI_ADDR_CTRL, 32'h3);
		@(posedge clock);
		pa <= 8'h01;
		for (i = 0; i < 8 && wake !== 1'b1; i = i + 1) @(posedge clock);
		chk("wake", 1, wake);
		rd(`PCI_ADDR_A_FLAGS, 32'h01);
		// zero only the bits just seen set
		bus(1'b1, `PCI_ADDR_A_FLAGS, got & ~32'h01);
		rd(`PCI_ADDR_CTRL, 32'h1);
		rd(`PCI_ADDR_IRQ_STAT, 32'h5);
		bus(1'b1, `PCI_ADDR_A_FLAGS, 32'h0);
		bus(1'b1, `PCI_ADDR_CTRL, 32'h2);
		pins(8'h00, 8'h00);
		chk("wake", 0, wake);
		rd(`PCI_ADDR_CTRL, 32'h6);
	endtask
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		t_regs;
		t_edges;
		t_race;
		t_irq;
		t_sleep;
		give_verdict;
	end
endmodule // tb_top
bind pci_pin_change pci_chk #(.WIDTH(WIDTH)) chk (.clock, .rst_n,
	.first_gpio_port, .second_gpio_port, .wb_cyc_i, .wb_stb_i,
	.wb_dat_o, .wb_ack_o, .wb_err_o, .change_irq_summary_flag,
	.pin_change_interrupt, .wake_request, .irq);
